//--- brpf_dev.sv
// Device end: formats a received block packet into FIFO quadlets
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// R1: Token quadlet always precedes header quadlets
// R2: Second quadlet: destination ID high, control low
// R3: Third/fourth quadlets: source ID, 48-bit offset
// R4: Fifth quadlet: length high, extended code low
// R5: Length counts block data bytes only
// R6: Length meaning depends on code; host ignores
// R7: First data byte lands in byte 0
// R8: Short final quadlet padded with zeros
// R9: Token complete flag marks last block
// R10: Speed coded 00/01/10, never 11
// R11: Token reports number of data quadlets
// R12: Token carries returned acknowledge code
// R13: Destination is 10-bit bus, 6-bit node
// R14: Host matches responses by transaction label
// R15: Retry code passed through unchanged
// R16: Host reads lock response code, top bits
// R17: Host treats offset as quadlet aligned
// R18: Host reads token, header, then data quadlets
module brpf_dev (
  input wire logic mclk,
  input wire logic rst_n,
  brpf_if.dev bus,
  input wire logic hdr_valid,
  output logic hdr_ready,
  input wire logic [9:0] dest_bus,
  input wire logic [5:0] dest_node,
  input wire logic [5:0] tlabel,
  input wire logic [1:0] retry_code,
  input wire logic [3:0] tcode,
  input wire logic [3:0] priority_lvl,
  input wire logic [15:0] src_id,
  input wire logic [47:0] dest_offset,
  input wire logic [15:0] data_len,
  input wire logic [15:0] ext_tcode,
  input wire logic [1:0] rx_speed,
  input wire logic [3:0] returned_ack_code,
  input wire logic packet_complete_flag,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready
);

  // ----------------------------------------
  // State and storage
  // ----------------------------------------
  typedef enum logic [1:0] {
    BRPF_IDLE = 2'b00,
    BRPF_HDR = 2'b01,
    BRPF_DATA = 2'b10,
    BRPF_PUSH = 2'b11
  } brpf_dev_state_t;

  brpf_dev_state_t state_r;
  logic [31:0] hq_r [brpf_pkg::HDR_QUADS];
  logic [2:0] idx_r;
  logic [15:0] left_r;
  logic [1:0] lane_r;
  logic [31:0] acc_r;
  logic q_valid_r;
  logic [31:0] q_data_r;
  logic hdr_ready_r;
  logic byte_ready_r;
  logic hdr_take;
  logic byte_take;
  logic out_free;
  logic [1:0] spd_nxt;
  logic [15:0] qcnt_nxt;

  assign hdr_take = hdr_valid && hdr_ready_r;
  assign byte_take = byte_valid && byte_ready_r;
  assign out_free = !q_valid_r || bus.q_ready;
  assign qcnt_nxt = brpf_pkg::has_block_data(tcode) ? brpf_pkg::quad_count(data_len) : 16'h0;

  // R10: clamp undefined code
  always_comb
  begin
    spd_nxt = rx_speed;
    if (rx_speed == 2'h3)
    begin
      spd_nxt = brpf_pkg::SPD_S400;
    end
  end

  // ----------------------------------------
  // Header capture
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < brpf_pkg::HDR_QUADS; i++)
      begin
        hq_r[i] <= brpf_pkg::QUAD_RST;
      end
    end
    else if (hdr_take)
    begin
      // R1: token built first, rest zero
      hq_r[0] <= brpf_pkg::QUAD_RST;
      // R9: packet complete flag
      hq_r[0][brpf_pkg::TOK_DONE_POS] <= packet_complete_flag;
      // R10: speed field
      hq_r[0][brpf_pkg::TOK_SPD_LSB +: 2] <= spd_nxt;
      // R11: data quadlet count
      hq_r[0][brpf_pkg::TOK_WC_LSB +: brpf_pkg::WC_W] <= qcnt_nxt[brpf_pkg::WC_W-1:0];
      hq_r[0][brpf_pkg::TOK_TC_LSB +: 4] <= tcode;
      // R12: returned ack code
      hq_r[0][brpf_pkg::TOK_ACK_LSB +: 4] <= returned_ack_code;
      // R13: bus and node packed
      hq_r[1][brpf_pkg::BUS_LSB +: 10] <= dest_bus;
      hq_r[1][brpf_pkg::NODE_LSB +: 6] <= dest_node;
      // R2: control in low half
      hq_r[1][brpf_pkg::TL_LSB +: 6] <= tlabel;
      // R15: retry code unchanged
      hq_r[1][brpf_pkg::RT_LSB +: 2] <= retry_code;
      hq_r[1][brpf_pkg::TC_LSB +: 4] <= tcode;
      hq_r[1][brpf_pkg::PRI_LSB +: 4] <= priority_lvl;
      // R3: source and offset split
      hq_r[2] <= {src_id, dest_offset[47:32]};
      hq_r[3] <= dest_offset[31:0];
      // R4: length and extended code
      // R5: length covers data bytes only
      hq_r[4] <= {data_len, ext_tcode};
    end
  end

  // ----------------------------------------
  // Sequencer and output register
  // ----------------------------------------
  // Output only advances when the reader accepted, so the FIFO reader stalls us
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= BRPF_IDLE;
      idx_r <= 3'h0;
      left_r <= 16'h0;
      q_valid_r <= 1'b0;
      q_data_r <= brpf_pkg::QUAD_RST;
      hdr_ready_r <= 1'b1;
      byte_ready_r <= 1'b0;
    end
    else
    begin
      if (bus.q_ready)
      begin
        q_valid_r <= 1'b0;
      end
      case (state_r)
        BRPF_IDLE:
        begin
          if (hdr_take)
          begin
            hdr_ready_r <= 1'b0;
            idx_r <= 3'h0;
            // R6: no data bytes for read requests or write responses
            left_r <= brpf_pkg::has_block_data(tcode) ? data_len : 16'h0;
            state_r <= BRPF_HDR;
          end
        end
        BRPF_HDR:
        begin
          // R1: token then header in order
          if (out_free)
          begin
            q_valid_r <= 1'b1;
            q_data_r <= hq_r[idx_r];
            idx_r <= idx_r + 3'h1;
            if (idx_r == brpf_pkg::LAST_HDR_IDX)
            begin
              // R4: data follows fifth quadlet
              if (left_r == 16'h0)
              begin
                hdr_ready_r <= 1'b1;
                state_r <= BRPF_IDLE;
              end
              else
              begin
                byte_ready_r <= 1'b1;
                state_r <= BRPF_DATA;
              end
            end
          end
        end
        BRPF_DATA:
        begin
          if (byte_take)
          begin
            left_r <= left_r - 16'h1;
            // R8: stop early on last byte
            if (lane_r == 2'h3 || left_r == 16'h1)
            begin
              byte_ready_r <= 1'b0;
              state_r <= BRPF_PUSH;
            end
          end
        end
        BRPF_PUSH:
        begin
          if (out_free)
          begin
            q_valid_r <= 1'b1;
            q_data_r <= acc_r;
            if (left_r == 16'h0)
            begin
              hdr_ready_r <= 1'b1;
              state_r <= BRPF_IDLE;
            end
            else
            begin
              byte_ready_r <= 1'b1;
              state_r <= BRPF_DATA;
            end
          end
        end
        default:
        begin
          state_r <= BRPF_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Byte packing
  // ----------------------------------------
  // Cleared on every push, so unused lanes of a short quadlet stay zero
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_r <= brpf_pkg::QUAD_RST;
      lane_r <= 2'h0;
    end
    else if (state_r == BRPF_PUSH && out_free)
    begin
      // R8: zero padding by clear
      acc_r <= brpf_pkg::QUAD_RST;
      lane_r <= 2'h0;
    end
    else if (byte_take)
    begin
      // R7: first byte in byte 0
      acc_r <= acc_r | ({byte_data, 24'h0} >> {lane_r, 3'h0});
      lane_r <= lane_r + 2'h1;
    end
  end

  assign bus.q_valid = q_valid_r;
  assign bus.q_data = q_data_r;
  assign hdr_ready = hdr_ready_r;
  assign byte_ready = byte_ready_r;

endmodule
`default_nettype wire

//--- brpf_pkg.sv
// Shared constants, field layouts and helpers for the block receive formatter
package brpf_pkg;

  // ----------------------------------------
  // Field widths
  // ----------------------------------------
  localparam int unsigned QW = 32;
  localparam int unsigned LEN_W = 16;
  localparam int unsigned OFS_W = 48;
  localparam int unsigned WC_W = 8;
  localparam int unsigned HDR_QUADS = 5;
  localparam logic [2:0] LAST_HDR_IDX = 3'h4;

  // ----------------------------------------
  // Token layout (bit index, lsb = 0)
  // ----------------------------------------
  localparam int unsigned TOK_DONE_POS = 19;
  localparam int unsigned TOK_SPD_LSB = 17;
  localparam int unsigned TOK_WC_LSB = 8;
  localparam int unsigned TOK_TC_LSB = 4;
  localparam int unsigned TOK_ACK_LSB = 0;

  // ----------------------------------------
  // Header quadlet layouts
  // ----------------------------------------
  localparam int unsigned ID_LSB = 16;
  localparam int unsigned BUS_LSB = 22;
  localparam int unsigned NODE_LSB = 16;
  localparam int unsigned TL_LSB = 10;
  localparam int unsigned RT_LSB = 8;
  localparam int unsigned TC_LSB = 4;
  localparam int unsigned PRI_LSB = 0;
  localparam int unsigned OFSH_LSB = 0;
  localparam int unsigned RCODE_LSB = 12;
  localparam int unsigned LEN_LSB = 16;
  localparam int unsigned XTC_LSB = 0;

  // ----------------------------------------
  // Codes and reset values
  // ----------------------------------------
  localparam logic [1:0] SPD_S100 = 2'h0;
  localparam logic [1:0] SPD_S200 = 2'h1;
  localparam logic [1:0] SPD_S400 = 2'h2;
  localparam logic [1:0] RT_NEW = 2'h0;
  localparam logic [1:0] RT_RETRY_X = 2'h1;
  localparam logic [1:0] RT_RETRY_A = 2'h2;
  localparam logic [1:0] RT_RETRY_B = 2'h3;
  localparam logic [3:0] TC_WR_BLOCK = 4'h1;
  localparam logic [3:0] TC_WR_RESP = 4'h2;
  localparam logic [3:0] TC_RD_BLOCK_RESP = 4'h7;
  localparam logic [3:0] TC_LOCK_REQ = 4'h9;
  localparam logic [3:0] TC_LOCK_RESP = 4'hb;
  localparam logic [31:0] QUAD_RST = 32'h0;

  // Block data travels only with these transaction codes
  function automatic logic has_block_data(input logic [3:0] tc);
    has_block_data = (tc == TC_WR_BLOCK) || (tc == TC_RD_BLOCK_RESP) ||
                     (tc == TC_LOCK_REQ) || (tc == TC_LOCK_RESP);
  endfunction

  // Quadlets needed for a byte count, rounded up
  function automatic logic [LEN_W-1:0] quad_count(input logic [LEN_W-1:0] len);
    logic [LEN_W:0] sum;
    sum = {1'b0, len} + 17'h3;
    quad_count = {1'b0, sum[LEN_W:2]};
  endfunction

endpackage

//--- brpf_if.sv
// Quadlet channel between the formatter and the receive FIFO reader
`timescale 1ns/1ns
`default_nettype none
interface brpf_if;
  logic q_valid;
  logic [31:0] q_data;
  logic q_ready;

  modport dev (output q_valid, output q_data, input q_ready);
  modport host (input q_valid, input q_data, output q_ready);
endinterface
`default_nettype wire

//--- brpf_host.sv
// Host end: reads formatted block packets from the receive FIFO
`timescale 1ns/1ns
`default_nettype none
module brpf_host (
  input wire logic mclk,
  input wire logic rst_n,
  brpf_if.host bus,
  input wire logic hold,
  output logic hdr_valid,
  output logic [31:0] token,
  output logic [15:0] dest_id,
  output logic [5:0] tlabel,
  output logic [1:0] retry_code,
  output logic [3:0] tcode,
  output logic [15:0] src_id,
  output logic [47:0] dest_offset,
  output logic [3:0] resp_code,
  output logic offset_misaligned,
  output logic [15:0] data_len,
  output logic len_meaningful,
  output logic [15:0] ext_tcode,
  output logic count_mismatch,
  output logic data_valid,
  output logic [31:0] data_q,
  output logic data_last
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {
    BRPF_H_TOKEN = 2'b00,
    BRPF_H_HDR = 2'b01,
    BRPF_H_DATA = 2'b10
  } brpf_host_state_t;

  brpf_host_state_t state_r;
  logic [2:0] idx_r;
  logic [15:0] left_r;
  logic ready_r;
  logic hdr_valid_r;
  logic [31:0] token_r;
  logic [31:0] q1_r;
  logic [31:0] q2_r;
  logic [31:0] q3_r;
  logic [31:0] q4_r;
  logic [3:0] resp_r;
  logic misal_r;
  logic len_ok_r;
  logic mism_r;
  logic data_valid_r;
  logic [31:0] data_q_r;
  logic data_last_r;
  logic take;
  logic [3:0] tc_w;
  logic [15:0] len_w;
  logic [15:0] need_w;

  assign take = bus.q_valid && ready_r;
  assign tc_w = q1_r[brpf_pkg::TC_LSB +: 4];
  assign len_w = bus.q_data[brpf_pkg::LEN_LSB +: brpf_pkg::LEN_W];
  assign need_w = brpf_pkg::has_block_data(tc_w) ? brpf_pkg::quad_count(len_w) : 16'h0;

  // ----------------------------------------
  // Back-pressure
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_r <= 1'b0;
    end
    else
    begin
      ready_r <= !hold;
    end
  end

  // ----------------------------------------
  // Quadlet walk
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= BRPF_H_TOKEN;
      idx_r <= 3'h0;
      left_r <= 16'h0;
      token_r <= brpf_pkg::QUAD_RST;
      q1_r <= brpf_pkg::QUAD_RST;
      q2_r <= brpf_pkg::QUAD_RST;
      q3_r <= brpf_pkg::QUAD_RST;
      q4_r <= brpf_pkg::QUAD_RST;
      resp_r <= 4'h0;
      misal_r <= 1'b0;
      len_ok_r <= 1'b0;
      mism_r <= 1'b0;
      hdr_valid_r <= 1'b0;
      data_valid_r <= 1'b0;
      data_q_r <= brpf_pkg::QUAD_RST;
      data_last_r <= 1'b0;
    end
    else
    begin
      hdr_valid_r <= 1'b0;
      data_valid_r <= 1'b0;
      data_last_r <= 1'b0;
      if (take)
      begin
        case (state_r)
          BRPF_H_TOKEN:
          begin
            // R18: token read first
            token_r <= bus.q_data;
            idx_r <= 3'h1;
            state_r <= BRPF_H_HDR;
          end
          BRPF_H_HDR:
          begin
            idx_r <= idx_r + 3'h1;
            if (idx_r == 3'h1)
            begin
              // R14: label kept for request matching
              q1_r <= bus.q_data;
            end
            else if (idx_r == 3'h2)
            begin
              q2_r <= bus.q_data;
              // R16: lock response code
              resp_r <= (tc_w == brpf_pkg::TC_LOCK_RESP) ? bus.q_data[brpf_pkg::RCODE_LSB +: 4] : 4'h0;
            end
            else if (idx_r == 3'h3)
            begin
              q3_r <= bus.q_data;
              // R17: offset must be quadlet aligned
              misal_r <= bus.q_data[1:0] != 2'h0;
            end
            else
            begin
              q4_r <= bus.q_data;
              // R6: length ignored for write responses
              len_ok_r <= tc_w != brpf_pkg::TC_WR_RESP;
              mism_r <= token_r[brpf_pkg::TOK_WC_LSB +: brpf_pkg::WC_W] != need_w[brpf_pkg::WC_W-1:0];
              hdr_valid_r <= 1'b1;
              // R18: then rounded-up data quadlets
              left_r <= need_w;
              state_r <= (need_w == 16'h0) ? BRPF_H_TOKEN : BRPF_H_DATA;
            end
          end
          BRPF_H_DATA:
          begin
            data_valid_r <= 1'b1;
            data_q_r <= bus.q_data;
            data_last_r <= left_r == 16'h1;
            left_r <= left_r - 16'h1;
            if (left_r == 16'h1)
            begin
              state_r <= BRPF_H_TOKEN;
            end
          end
          default:
          begin
            state_r <= BRPF_H_TOKEN;
          end
        endcase
      end
    end
  end

  assign bus.q_ready = ready_r;
  assign hdr_valid = hdr_valid_r;
  assign token = token_r;
  assign dest_id = q1_r[brpf_pkg::ID_LSB +: 16];
  assign tlabel = q1_r[brpf_pkg::TL_LSB +: 6];
  assign retry_code = q1_r[brpf_pkg::RT_LSB +: 2];
  assign tcode = q1_r[brpf_pkg::TC_LSB +: 4];
  assign src_id = q2_r[brpf_pkg::ID_LSB +: 16];
  // Reserved offset bits hidden for lock responses
  assign dest_offset = {(tcode == brpf_pkg::TC_LOCK_RESP) ? 16'h0 : q2_r[15:0], q3_r};
  assign resp_code = resp_r;
  assign offset_misaligned = misal_r;
  assign data_len = q4_r[brpf_pkg::LEN_LSB +: brpf_pkg::LEN_W];
  assign len_meaningful = len_ok_r;
  assign ext_tcode = q4_r[brpf_pkg::XTC_LSB +: 16];
  assign count_mismatch = mism_r;
  assign data_valid = data_valid_r;
  assign data_q = data_q_r;
  assign data_last = data_last_r;

endmodule
`default_nettype wire

//--- brpf_assertions.sv
// Checker for the quadlet channel between formatter and reader
`timescale 1ns/1ns
`default_nettype none
module brpf_assertions (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic q_valid,
  input wire logic [31:0] q_data,
  input wire logic q_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic xf;
  logic dat;
  logic [3:0] pos_r;
  logic [3:0] tc_r;
  logic [7:0] cnt_r;
  logic dat_r;
  logic [15:0] left_r;
  logic [15:0] len_r;
  logic [15:0] need;
  logic [31:0] pad;
  assign xf = q_valid && q_ready;
  assign dat = q_data[7:4] inside {4'h1, 4'h7, 4'h9, 4'hb};
  assign need = {2'h0, q_data[31:18]} + {15'h0, |q_data[17:16]};
  // ----------------------------------------
  // Packet position tracking
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_r <= 4'h0;
      tc_r <= 4'h0;
      cnt_r <= 8'h0;
      dat_r <= 1'b0;
      left_r <= 16'h0;
      len_r <= 16'h0;
    end
    else if (xf)
    begin
      if (pos_r == 4'h0)
      begin
        tc_r <= q_data[7:4];
        cnt_r <= q_data[15:8];
        dat_r <= dat;
      end
      if (pos_r == 4'h4)
      begin
        len_r <= q_data[31:16];
        left_r <= dat_r ? need : 16'h0;
      end
      else if (pos_r == 4'h5)
      begin
        left_r <= left_r - 16'h1;
      end
      // Data phase parks at 5 so long packets need no wide counter
      if ((pos_r == 4'h4 && (!dat_r || need == 16'h0)) || (pos_r == 4'h5 && left_r == 16'h1))
      begin
        pos_r <= 4'h0;
      end
      else if (pos_r != 4'h5)
      begin
        pos_r <= pos_r + 4'h1;
      end
    end
  end
  always_comb
  begin
    case (len_r[1:0])
      2'h1: pad = 32'h00ffffff;
      2'h2: pad = 32'h0000ffff;
      2'h3: pad = 32'h000000ff;
      default: pad = 32'h0;
    endcase
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_token_speed_legal: assert property (xf && pos_r == 4'h0 |-> q_data[18:17] != 2'h3)
    else $error("token speed code 11 sent");
  a_token_spare_zero: assert property (xf && pos_r == 4'h0 |-> q_data[31:20] == 12'h0 && !q_data[16])
    else $error("token spare bits not zero");
  a_ctrl_tcode_copy: assert property (xf && pos_r == 4'h1 |-> q_data[7:4] == tc_r)
    else $error("control tcode differs from token");
  a_count_vs_length: assert property (xf && pos_r == 4'h4 && dat_r |-> cnt_r == need[7:0])
    else $error("token count disagrees with length");
  a_header_no_gap: assert property (xf && pos_r < 4'h4 |=> q_valid)
    else $error("header quadlet not ready after take");
  a_valid_holds: assert property (q_valid && !q_ready |=> q_valid)
    else $error("valid dropped before take");
  a_data_holds: assert property (q_valid && !q_ready |=> $stable(q_data))
    else $error("quadlet changed before take");
  a_pad_zero: assert property (xf && pos_r == 4'h5 && left_r == 16'h1 |-> (q_data & pad) == 32'h0)
    else $error("final quadlet padding not zero");
  c_padded_last: cover property (xf && pos_r == 4'h5 && left_r == 16'h1 && len_r[1:0] != 2'h0);
  c_stall: cover property (q_valid && !q_ready);
  c_no_data: cover property (xf && pos_r == 4'h4 && !dat_r);
endmodule
`default_nettype wire

//--- test_block_receive_packet_formatter.sv
// Testbench joining formatter and reader ends
`timescale 1ns/1ns
`default_nettype none
module test_block_receive_packet_formatter;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hold = 1'b0;
  logic stall = 1'b0;
  logic hdr_valid = 1'b0;
  logic [9:0] dest_bus = 10'h0;
  logic [5:0] dest_node = 6'h0;
  logic [5:0] tlabel = 6'h0;
  logic [1:0] retry_code = 2'h0;
  logic [3:0] priority_lvl = 4'h0;
  logic [3:0] tcode = 4'h0;
  logic [15:0] src_id = 16'h0;
  logic [47:0] dest_offset = 48'h0;
  logic [15:0] data_len = 16'h0;
  logic [15:0] ext_tcode = 16'h0;
  logic [1:0] rx_speed = 2'h0;
  logic [3:0] returned_ack_code = 4'h0;
  logic packet_complete_flag = 1'b0;
  logic byte_valid = 1'b0;
  logic [7:0] byte_data = 8'h0;
  logic hdr_ready, byte_ready, h_hv, h_mis, h_lm, h_cm, h_dv, h_dl;
  logic [31:0] h_tok, h_dq, e_tok, w, e;
  logic [15:0] h_did, h_src, h_len, h_xtc;
  logic [5:0] h_tl;
  logic [1:0] h_rt;
  logic [3:0] h_tc, h_rc;
  logic [47:0] h_off;
  logic [31:0] wq[$];
  logic [31:0] dq[$];
  logic seen = 1'b0;
  int errors = 0;
  int tests_run = 0;
  logic [3:0] tc_t[6] = '{4'h1, 4'h7, 4'h9, 4'hb, 4'h2, 4'h5};
  logic [15:0] len_t[6] = '{16'h5, 16'h8, 16'h0, 16'h3, 16'h7, 16'h10};
  logic [1:0] spd_t[6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h3, 2'h1};
  brpf_if bus_if();
  brpf_dev i_brpf_dev (.mclk(mclk), .rst_n(rst_n), .bus(bus_if), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready),
    .dest_bus(dest_bus), .dest_node(dest_node), .tlabel(tlabel), .retry_code(retry_code), .tcode(tcode),
    .priority_lvl(priority_lvl), .src_id(src_id), .dest_offset(dest_offset), .data_len(data_len),
    .ext_tcode(ext_tcode),
    .rx_speed(rx_speed), .returned_ack_code(returned_ack_code), .packet_complete_flag(packet_complete_flag),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready));
  brpf_host i_brpf_host (.mclk(mclk), .rst_n(rst_n), .bus(bus_if), .hold(hold), .hdr_valid(h_hv), .token(h_tok),
    .dest_id(h_did), .tlabel(h_tl), .retry_code(h_rt), .tcode(h_tc), .src_id(h_src), .dest_offset(h_off),
    .resp_code(h_rc), .offset_misaligned(h_mis), .data_len(h_len), .len_meaningful(h_lm), .ext_tcode(h_xtc),
    .count_mismatch(h_cm), .data_valid(h_dv), .data_q(h_dq), .data_last(h_dl));
  brpf_assertions i_brpf_assertions (.mclk(mclk), .rst_n(rst_n), .q_valid(bus_if.q_valid),
    .q_data(bus_if.q_data), .q_ready(bus_if.q_ready));
  initial
  begin
    forever #50 mclk = ~mclk;
  end
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Back-pressure toggles every cycle while a stall test runs
  always @(negedge mclk) hold <= stall ? ~hold : 1'b0;
  always @(posedge mclk)
  begin
    if (rst_n && bus_if.q_valid && bus_if.q_ready)
    begin
      w = wq.pop_front();
      chk("wire", w, bus_if.q_data);
    end
  end
  always @(negedge mclk)
  begin
    if (rst_n && h_hv)
    begin
      seen = 1'b1;
      chk("token", e_tok, h_tok);
      chk("dest_id", {dest_bus, dest_node}, h_did);
      chk("retry", retry_code, h_rt);
      chk("tlabel", tlabel, h_tl);
      chk("tcode", tcode, h_tc);
      chk("src", src_id, h_src);
      chk("offset", tcode == 4'hb ? {16'h0, dest_offset[31:0]} : dest_offset, h_off);
      chk("resp", tcode == 4'hb ? dest_offset[47:44] : 4'h0, h_rc);
      chk("misaligned", |dest_offset[1:0], h_mis);
      chk("len", data_len, h_len);
      chk("len_used", tcode != 4'h2, h_lm);
      chk("xtc", ext_tcode, h_xtc);
      chk("count_err", 1'b0, h_cm);
    end
    if (rst_n && h_dv)
    begin
      e = dq.pop_front();
      chk("data", e, h_dq);
      chk("last", dq.size() == 0, h_dl);
    end
  end
  // ----------------------------------------
  // One packet through both ends
  // ----------------------------------------
  task automatic send(input int i);
    logic [31:0] q;
    int n;
    n = (tc_t[i] inside {4'h1, 4'h7, 4'h9, 4'hb}) ? int'(len_t[i]) : 0;
    stall = (i == 1);
    dest_bus = 10'h2a5 + 10'(i);
    dest_node = 6'h11 + 6'(i);
    tlabel = 6'h20 + 6'(i);
    retry_code = 2'(i);
    priority_lvl = 4'(i);
    tcode = tc_t[i];
    src_id = 16'hc0d0 + 16'(i);
    dest_offset = {4'ha, 44'h1234567890} + 48'(i);
    data_len = len_t[i];
    ext_tcode = 16'h2 + 16'(i);
    rx_speed = spd_t[i];
    returned_ack_code = 4'h1 + 4'(i);
    packet_complete_flag = (i != 3);
    // Speed code 11 is folded onto 10
    e_tok = {12'h0, packet_complete_flag, rx_speed == 2'h3 ? 2'h2 : rx_speed, 1'b0, 8'((n + 3) / 4), tcode,
      returned_ack_code};
    wq = '{e_tok, {dest_bus, dest_node, tlabel, retry_code, tcode, priority_lvl}, {src_id, dest_offset[47:32]},
      dest_offset[31:0], {data_len, ext_tcode}};
    q = 32'h0;
    for (int k = 0; k < n; k++)
    begin
      q = q | ({24'h0, 8'(i * 16 + k + 1)} << (24 - 8 * (k % 4)));
      if (k % 4 == 3 || k == n - 1)
      begin
        wq.push_back(q);
        dq.push_back(q);
        q = 32'h0;
      end
    end
    seen = 1'b0;
    hdr_valid = 1'b1;
    do @(posedge mclk); while (!hdr_ready);
    @(negedge mclk);
    hdr_valid = 1'b0;
    for (int k = 0; k < n; k++)
    begin
      byte_data = 8'(i * 16 + k + 1);
      byte_valid = 1'b1;
      do @(posedge mclk); while (!byte_ready);
      @(negedge mclk);
    end
    byte_valid = 1'b0;
    while (!(seen && wq.size() == 0 && dq.size() == 0)) @(negedge mclk);
    $display("Test %0d done", i);
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) send(i);
    conclude();
  end
  // Six short packets need well under 500 cycles
  initial
  begin
    repeat (3000) @(posedge mclk);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
